//--- atb_bridge.sv
// Top module of the bus bridge that turns system bus transfers into peripheral transfers.
// Notes on behaviour
// - Reset input is active low and clears the bridge logic.
// - Slave address input is a full 32-bit system address.
// - Ready to bus goes high on completion, low only while a read or a transfer behind a pending write waits.
// - Response output is always OKAY.
// - Write data is always driven and changes only in write cycles.
// - Enable rises at the second edge of a transfer and falls at the third.
// - One select output per peripheral, meaning chosen and transfer requested.
// - Select rises with the peripheral address and falls at transfer end.
// - Peripheral address width is configurable up to 32 bits.
// - Peripheral address valid after the first edge of each transfer.
// - Address moves to the next value if another transfer follows, else holds.
// - Direction output high for write, low for read, timed like the address.
// - Only requests of the granted master, seen via bus ready, are converted.
// - Selects decoded from the address and enabled only during a transfer.
// - Unmapped address selects nothing yet completes normally.
// - Controller is an eight-state machine driving ready and peripheral outputs.
// - A read with no pending write gets one wait state until read data reaches the bus.
// - A write waits one cycle for write data, then starts the peripheral write.
// - A read after a pending write waits two extra states for the write to end.
// - Registers clock on the rising edge and clear on the low reset, except ready to bus, which resets high, and the state, which resets to ATB_IDLE.
`timescale 1ns/1ps
`default_nettype none
module atb_bridge #(
	parameter int unsigned PADDR_W = atb_pkg::PADDR_W_DEF,
	parameter int unsigned NUM_PERIPH = atb_pkg::NUM_PERIPH_DEF,
	parameter int unsigned SEL_LSB = atb_pkg::SEL_LSB_DEF,
	parameter int unsigned SEL_BITS = atb_pkg::SEL_BITS_DEF
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// System bus slave
	input wire logic [atb_pkg::HADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [atb_pkg::DATA_W-1:0] hwdata_i,
	input wire logic bridge_slave_select_i,
	input wire logic bus_ready_in_i,
	output logic [atb_pkg::DATA_W-1:0] hrdata_o,
	output logic ready_to_bus_o,
	output logic [1:0] hresp_o,
	// Peripheral bus
	input wire logic [atb_pkg::DATA_W-1:0] prdata_i,
	output logic [atb_pkg::DATA_W-1:0] pwdata_o,
	output logic penable_o,
	output logic [NUM_PERIPH-1:0] peripheral_selects_o,
	output logic [PADDR_W-1:0] paddr_o,
	output logic pwrite_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Valid transfer detection and address phase capture.

	atb_pkg::atb_state_e state;
	atb_pkg::atb_state_e next_state;
	atb_pkg::atb_req_s held;
	atb_pkg::atb_req_s cur;
	logic valid;
	logic valid_read;
	logic valid_write;
	logic held_valid;
	logic [atb_pkg::HADDR_W-1:0] sel_addr;
	logic next_psel_en;
	logic [NUM_PERIPH-1:0] next_selects;

	// Transfers only count when the granted master's previous transfer has ended.
	assign valid = bridge_slave_select_i && bus_ready_in_i
		&& (htrans_i == atb_pkg::TRANS_NONSEQ || htrans_i == atb_pkg::TRANS_SEQ);
	assign valid_read = valid && !hwrite_i;
	assign valid_write = valid && hwrite_i;
	assign cur.addr = haddr_i;
	assign cur.write = hwrite_i;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			held <= '0;
		end else if (valid) begin
			held <= cur;
		end
	end

	// Marks a registered request, read or write, not yet started on the peripheral bus.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			held_valid <= 1'b0;
		end else if (bus_ready_in_i) begin
			held_valid <= valid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transfer state machine.

	always_comb begin
		next_state = state;
		unique case (state)
			atb_pkg::ATB_IDLE: begin
				if (valid_read) begin
					next_state = atb_pkg::ATB_READ;
				end else if (valid_write) begin
					next_state = atb_pkg::ATB_WWAIT;
				end
			end
			atb_pkg::ATB_READ: begin
				next_state = atb_pkg::ATB_RENABLE;
			end
			atb_pkg::ATB_WWAIT: begin
				next_state = valid ? atb_pkg::ATB_WRITEP : atb_pkg::ATB_WRITE;
			end
			atb_pkg::ATB_WRITE: begin
				next_state = valid ? atb_pkg::ATB_WENABLEP : atb_pkg::ATB_WENABLE;
			end
			atb_pkg::ATB_WRITEP: begin
				next_state = atb_pkg::ATB_WENABLEP;
			end
			atb_pkg::ATB_RENABLE, atb_pkg::ATB_WENABLE: begin
				if (valid_read) begin
					next_state = atb_pkg::ATB_READ;
				end else if (valid_write) begin
					next_state = atb_pkg::ATB_WWAIT;
				end else begin
					next_state = atb_pkg::ATB_IDLE;
				end
			end
			atb_pkg::ATB_WENABLEP: begin
				if (!held.write) begin
					next_state = atb_pkg::ATB_READ;
				end else if (valid) begin
					next_state = atb_pkg::ATB_WRITEP;
				end else begin
					next_state = atb_pkg::ATB_WRITE;
				end
			end
			default: begin
				next_state = atb_pkg::ATB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state <= atb_pkg::ATB_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Peripheral output generation.

	// Reads use the live address; writes and pending transfers use the held one.
	assign sel_addr = (next_state == atb_pkg::ATB_READ && state != atb_pkg::ATB_WENABLEP)
		? haddr_i : held.addr;
	assign next_psel_en = next_state == atb_pkg::ATB_READ || next_state == atb_pkg::ATB_WRITE
		|| next_state == atb_pkg::ATB_WRITEP;

	atb_decode #(
		.NUM_PERIPH(NUM_PERIPH),
		.SEL_LSB(SEL_LSB),
		.SEL_BITS(SEL_BITS)
	) u_decode (
		.addr_i(sel_addr),
		.enable_i(next_psel_en),
		.selects_o(next_selects)
	);

	// Address and direction load only when a transfer starts, so they hold between transfers.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			paddr_o <= '0;
			pwrite_o <= 1'b0;
		end else if (next_psel_en) begin
			paddr_o <= sel_addr[PADDR_W-1:0];
			pwrite_o <= next_state != atb_pkg::ATB_READ;
		end
	end

	// Selects follow the address edge and stay through the enable cycle.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			peripheral_selects_o <= '0;
		end else if (next_psel_en) begin
			peripheral_selects_o <= next_selects;
		end else if (next_state == atb_pkg::ATB_IDLE || next_state == atb_pkg::ATB_WWAIT) begin
			peripheral_selects_o <= '0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			penable_o <= 1'b0;
		end else begin
			penable_o <= next_state == atb_pkg::ATB_RENABLE || next_state == atb_pkg::ATB_WENABLE
				|| next_state == atb_pkg::ATB_WENABLEP;
		end
	end

	// Write data is captured in the wait or pending state, one cycle after its address phase.
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			pwdata_o <= '0;
		end else if (next_psel_en && next_state != atb_pkg::ATB_READ) begin
			pwdata_o <= hwdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// System bus answer.

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			hrdata_o <= '0;
		end else if (state == atb_pkg::ATB_READ) begin
			hrdata_o <= prdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			ready_to_bus_o <= 1'b1;
		end else begin
			ready_to_bus_o <= !(next_state == atb_pkg::ATB_READ || next_state == atb_pkg::ATB_WRITEP
				|| (next_state == atb_pkg::ATB_WENABLEP && held_valid && !held.write));
		end
	end

	assign hresp_o = atb_pkg::RESP_OKAY;

endmodule : atb_bridge
`default_nettype wire

//--- atb_pkg.sv
// Package with constants, states and carrier types of the bus bridge.
package atb_pkg;

	localparam int unsigned HADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned PADDR_W_DEF = 16;
	localparam int unsigned NUM_PERIPH_DEF = 4;
	localparam int unsigned SEL_LSB_DEF = 12;
	localparam int unsigned SEL_BITS_DEF = 4;

	localparam logic [1:0] TRANS_IDLE = 2'h0;
	localparam logic [1:0] TRANS_BUSY = 2'h1;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;
	localparam logic [1:0] TRANS_SEQ = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;

	typedef enum logic [7:0] {
		ATB_IDLE = 8'h01,
		ATB_READ = 8'h02,
		ATB_WWAIT = 8'h04,
		ATB_WRITE = 8'h08,
		ATB_WRITEP = 8'h10,
		ATB_RENABLE = 8'h20,
		ATB_WENABLE = 8'h40,
		ATB_WENABLEP = 8'h80
	} atb_state_e;

	typedef struct packed {
		logic [HADDR_W-1:0] addr;
		logic write;
	} atb_req_s;

endpackage : atb_pkg

//--- atb_decode.sv
// Peripheral select decoder driven from the transfer address.
`timescale 1ns/1ps
`default_nettype none
module atb_decode #(
	parameter int unsigned NUM_PERIPH = atb_pkg::NUM_PERIPH_DEF,
	parameter int unsigned SEL_LSB = atb_pkg::SEL_LSB_DEF,
	parameter int unsigned SEL_BITS = atb_pkg::SEL_BITS_DEF
) (
	// Address and enable
	input wire logic [atb_pkg::HADDR_W-1:0] addr_i,
	input wire logic enable_i,
	// One-hot selects
	output logic [NUM_PERIPH-1:0] selects_o
);

	logic [SEL_BITS-1:0] slot;

	assign slot = addr_i[SEL_LSB +: SEL_BITS];

	// Slots at or above the peripheral count select nothing and still complete.
	genvar g;
	generate
		for (g = 0; g < NUM_PERIPH; g++) begin : g_sel
			assign selects_o[g] = enable_i && (slot == SEL_BITS'(g));
		end
	endgenerate

endmodule : atb_decode
`default_nettype wire

//--- atb_bridge_monitor.sv
// Checker for the bus bridge, watching only the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module atb_bridge_monitor #(
	parameter int unsigned PADDR_W = 16,
	parameter int unsigned NUM_PERIPH = 4
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Bridge outputs and peripheral data
	input wire logic [atb_pkg::DATA_W-1:0] hrdata_o,
	input wire logic ready_to_bus_o,
	input wire logic [1:0] hresp_o,
	input wire logic [atb_pkg::DATA_W-1:0] prdata_i,
	input wire logic [atb_pkg::DATA_W-1:0] pwdata_o,
	input wire logic penable_o,
	input wire logic [NUM_PERIPH-1:0] peripheral_selects_o,
	input wire logic [PADDR_W-1:0] paddr_o,
	input wire logic pwrite_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	a_resp_okay: assert property (hresp_o == atb_pkg::RESP_OKAY)
		else $error("response is not okay");
	a_enable_pulse: assert property (penable_o |=> !penable_o)
		else $error("enable held longer than one cycle");
	a_setup_hold: assert property (penable_o |-> $stable(paddr_o) && $stable(pwrite_o))
		else $error("address or direction moved during enable");
	a_sel_onehot: assert property ($onehot0(peripheral_selects_o))
		else $error("more than one select high");
	a_sel_decode: assert property (|peripheral_selects_o |->
		peripheral_selects_o == (NUM_PERIPH'(1) << paddr_o[15:12]))
		else $error("select does not match address");
	a_sel_enable: assert property ($rose(|peripheral_selects_o) |=> penable_o &&
		$stable(peripheral_selects_o))
		else $error("select not followed by enable");
	a_wdata_write: assert property ($changed(pwdata_o) |-> pwrite_o)
		else $error("write data changed outside a write");
	a_read_wait: assert property (|peripheral_selects_o && !pwrite_o && !penable_o |->
		!ready_to_bus_o ##1 ready_to_bus_o && penable_o)
		else $error("read wait state wrong");
	a_read_data: assert property (penable_o && !pwrite_o && |peripheral_selects_o |->
		hrdata_o == $past(prdata_i))
		else $error("read data not returned");
	a_write_seq: assert property (pwrite_o && |peripheral_selects_o && !penable_o |=>
		penable_o ##1 !penable_o)
		else $error("write enable timing wrong");
	a_reset_idle: assert property ($rose(reset_n_i) |-> ready_to_bus_o && !penable_o &&
		peripheral_selects_o == '0)
		else $error("outputs wrong after reset");
endmodule : atb_bridge_monitor
`default_nettype wire

//--- atb_periph_model.sv
// Peripheral model with one register per select slot.
`timescale 1ns/1ps
`default_nettype none
module atb_periph_model (
	input wire logic clock_i,
	input wire logic [3:0] sel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o
);
	logic [31:0] mem [4];
	logic [31:0] last = 32'h0;
	always @(posedge clock_i) begin
		if (|sel_i && penable_i && pwrite_i) mem[paddr_i[13:12]] <= pwdata_i;
		last <= prdata_o;
	end
	// Outside a read the bus shows a changing pattern so stale data cannot pass.
	assign prdata_o = (|sel_i && !pwrite_i) ? mem[paddr_i[13:12]] : ~last;
endmodule : atb_periph_model
`default_nettype wire

//--- atb_bridge_tb_top.sv
// Testbench for the bus bridge.
`timescale 1ns/1ps
`default_nettype none
module atb_bridge_tb_top;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, prdata, pwdata, rd;
	logic [1:0] htrans = atb_pkg::TRANS_IDLE, hresp;
	logic hwrite = 1'b0, hsel = 1'b0, ready, penable, pwrite;
	int sel_count = 0, en_count = 0;
	logic [3:0] sel;
	logic [15:0] paddr;
	int num_errors = 0, comparisons = 0;
	always #25 clock_i = ~clock_i;
	// Selects and enable are counted apart: an unmapped access still pulses enable.
	always @(posedge clock_i) begin
		if (|sel) sel_count++;
		if (penable) en_count++;
	end
	atb_bridge dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hwdata_i(hwdata),
		.bridge_slave_select_i(hsel), .bus_ready_in_i(ready), .hrdata_o(hrdata),
		.ready_to_bus_o(ready), .hresp_o(hresp), .prdata_i(prdata), .pwdata_o(pwdata),
		.penable_o(penable), .peripheral_selects_o(sel), .paddr_o(paddr), .pwrite_o(pwrite));
	atb_periph_model per (.clock_i(clock_i), .sel_i(sel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected value at %0t: %h not %h", $time, got, exp);
		end
	endtask : check
	// Samples ready at the negative edge so the completing edge is never raced.
	task automatic wait_ready(output logic [31:0] d);
		int n;
		for (n = 0; n < 20; n++) begin
			@(negedge clock_i);
			if (ready === 1'b1) break;
		end
		d = hrdata;
		if (n == 20) begin
			num_errors++;
			$display("unexpected hang at %0t", $time);
			end_sim();
		end
		@(posedge clock_i);
		#1;
	endtask : wait_ready
	// Write followed back to back by a read, returning the read data.
	task automatic write_read(input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		haddr = a;
		hwrite = 1'b1;
		htrans = atb_pkg::TRANS_NONSEQ;
		hsel = 1'b1;
		wait_ready(r);
		hwrite = 1'b0;
		hwdata = d;
		wait_ready(r);
		htrans = atb_pkg::TRANS_IDLE;
		hsel = 1'b0;
		wait_ready(r);
	endtask : write_read
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		@(negedge clock_i);
		check({30'h0, ready, penable}, 32'h2);
		check({28'h0, sel}, 32'h0);
		check({30'h0, hresp}, {30'h0, atb_pkg::RESP_OKAY});
		@(posedge clock_i);
		#1;
	endtask : test_reset
	task automatic test_slots();
		for (int i = 0; i < 4; i++) begin
			write_read({16'h0, i[3:0], 12'h008}, 32'h5a00c300 | i, rd);
			check(rd, 32'h5a00c300 | i);
		end
	endtask : test_slots
	task automatic test_unmapped();
		int c0;
		c0 = sel_count;
		write_read(32'h00005004, 32'h12345678, rd);
		check(sel_count - c0, 32'h0);
	endtask : test_unmapped
	task automatic test_ignored();
		int s0;
		int e0;
		s0 = sel_count;
		e0 = en_count;
		hsel = 1'b1;
		htrans = atb_pkg::TRANS_BUSY;
		repeat (2) @(posedge clock_i);
		#1;
		htrans = atb_pkg::TRANS_IDLE;
		repeat (2) @(posedge clock_i);
		#1;
		hsel = 1'b0;
		check(sel_count - s0, 32'h0);
		check(en_count - e0, 32'h0);
	endtask : test_ignored
	initial begin
		repeat (6) @(posedge clock_i);
		#1;
		reset_n_i = 1'b1;
		test_reset();
		test_slots();
		test_unmapped();
		test_ignored();
		end_sim();
	end
endmodule : atb_bridge_tb_top
bind atb_bridge atb_bridge_monitor #(.PADDR_W(PADDR_W), .NUM_PERIPH(NUM_PERIPH)) mon (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .hrdata_o(hrdata_o),
	.ready_to_bus_o(ready_to_bus_o), .hresp_o(hresp_o), .prdata_i(prdata_i),
	.pwdata_o(pwdata_o), .penable_o(penable_o), .peripheral_selects_o(peripheral_selects_o),
	.paddr_o(paddr_o), .pwrite_o(pwrite_o));
`default_nettype wire
